// >>> cpu_side_model.sv
// Purpose: Behavioural stand-in for the CPU core and the interrupt sources around the arbiter
// Assumes: Every change lands by non-blocking assignment right after a rising edge
// Notes: The fast request pin stays high for several cycles so the synchroniser sees one rise
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model
(
	input wire logic clk,
	output logic fast_req_pin,
	output logic [7:0] factor_evt,
	output logic [3:0] cpu_level,
	output logic sleep_mode
);
	initial
	begin
		fast_req_pin = 1'b0;
		factor_evt = 8'h00;
		cpu_level = 4'h0;
		sleep_mode = 1'b0;
	end

	// Only the request edge reaches the arbiter
	task automatic fire_fast();
		@(posedge clk);
		fast_req_pin <= 1'b1;
		repeat (4) @(posedge clk);
		fast_req_pin <= 1'b0;
	endtask : fire_fast

	task automatic pulse_factor(input logic [7:0] m);
		@(posedge clk);
		factor_evt <= m;
		@(posedge clk);
		factor_evt <= 8'h00;
	endtask : pulse_factor

	// Level is raised while a handler runs, which is what gates low-priority triggers
	task automatic set_mode(input logic [3:0] lvl, input logic slp);
		@(posedge clk);
		cpu_level <= lvl;
		sleep_mode <= slp;
	endtask : set_mode
endmodule : cpu_side_model
`default_nettype wire

// >>> dma_arb_pkg.sv
// Purpose: Shared constants and carrier types for the DMA request arbiter
// Assumes: One 100 MHz clock; plain register port with 20-bit byte addresses
// Notes: Offsets are byte addresses on the register port
package dma_arb_pkg;

	localparam int ADDR_W = 20;
	localparam int CHANS = 8;

	localparam logic [19:0] BASE_LO_OFS = 20'h48230;
	localparam logic [19:0] BASE_HI_OFS = 20'h48232;
	localparam logic [19:0] IRQ_EN_OFS = 20'h40270;
	localparam logic [19:0] FLAG_OFS = 20'h40280;
	localparam logic [19:0] REQ_OFS = 20'h40290;
	localparam logic [19:0] DONE_IRQ_EN_OFS = 20'h40294;
	localparam logic [19:0] METHOD_OFS = 20'h4029F;
	localparam logic [19:0] PRIO_OFS = 20'h402A0;
	localparam logic [19:0] CTRL_OFS = 20'h402A4;
	localparam logic [19:0] STATUS_OFS = 20'h402A8;
	localparam logic [19:0] COUNT_LO_OFS = 20'h402B0;
	localparam logic [19:0] COUNT_HI_OFS = 20'h402B4;

	localparam int METHOD_BIT = 0;
	localparam int CTRL_EN_BIT = 0;
	localparam int STATUS_FAST_FLAG_BIT = 0;
	localparam int PRIO_FIELD_STRIDE = 4;
	localparam int PRIO_FIELD_W = 3;

	localparam logic METHOD_RST = 1'b1;
	localparam logic [31:0] BASE_RST = 32'h0000_0000;
	localparam logic [31:0] PRIO_RST = 32'h0000_0000;
	localparam logic [7:0] BYTE_RST = 8'h00;

	localparam int CLK_PERIOD_NS = 10;
	localparam int FAST_XFER_NS = 80;
	localparam int DESC_XFER_NS = 40;
	localparam logic [7:0] FAST_XFER_CYCLES = 8'(FAST_XFER_NS / CLK_PERIOD_NS);
	localparam logic [7:0] DESC_XFER_CYCLES = 8'(DESC_XFER_NS / CLK_PERIOD_NS);

	typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} acc_size_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
		acc_size_e size;
	} reg_req_s;

	typedef struct packed {
		logic fast;
		logic desc;
		logic [2:0] chan;
		logic cpu;
	} grant_s;

endpackage : dma_arb_pkg

// >>> dma_req_arbiter.sv
// Purpose: Request arbitration, factor flags and base register for fast and descriptor DMA
// Assumes: Factor events, level and sleep come from logic on CLK; fast request is a pin
// Notes: One shared transfer circuit serves both kinds of transfer
// What this block does
// - Fast DMA wins over descriptor DMA and CPU
// - Fast request waits out running descriptor transfer
// - Descriptor and interrupt requests wait out fast transfer
// - All interrupts held during descriptor transfer
// - Triggers below current level are not accepted
// - Count zero clears request, keeps factor flag only if completion interrupt enabled
// - Completion interrupt disabled means no interrupt
// - Routed wake factor starts transfer, restarts oscillator
// - Priority fields are three bits, eight levels
// - Reset-only method: write one clears flag
// - Read/write method: write zero clears flag
// - Method bit selects clearing, reset default one
// - Base writes ignored, reads undefined during transfer
// - Half writes lower first, reads any order
// - Request flags share one byte, races undo
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dma_req_arbiter
	import dma_arb_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire reg_req_s REG_REQ,
	output logic [31:0] REG_RDATA,
	input wire logic FAST_REQ_PIN,
	input wire logic [7:0] FACTOR_EVT,
	input wire logic [3:0] CPU_LEVEL,
	input wire logic SLEEP_MODE,
	output logic IRQ_REQ,
	output logic [2:0] IRQ_PRIO,
	output logic [2:0] IRQ_SRC,
	output grant_s BUS_GRANT,
	output logic HS_OSC_RESTART
);

	typedef enum logic [1:0] {ST_IDLE, ST_FAST, ST_DESC} arb_state_e;

	function automatic logic [2:0] prio_of(input logic [31:0] w, input logic [2:0] ch);
		prio_of = w[32'(ch) * PRIO_FIELD_STRIDE +: PRIO_FIELD_W];
	endfunction : prio_of

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	arb_state_e state_q;
	logic fast_meta_q, fast_sync_q, fast_prev_q, fast_pend_q, fast_flag_q;
	logic [31:0] base_q, prio_q, rdata_q;
	logic [15:0] base_hold_q;
	logic base_hold_ok_q, method_q, ctrl_en_q, irq_q, osc_q;
	logic [7:0] irq_en_q, flag_q, req_q, done_irq_en_q;
	logic [7:0] count_q [CHANS];
	logic [2:0] chan_q, irq_prio_q, irq_src_q;
	logic eng_busy, eng_done, start_fast, start_desc, busy, zero_evt, fast_rise;
	logic [7:0] trig, flag_set, flag_clr, chan_hot;
	logic [3:0] pick;
	logic found;
	logic [2:0] best_prio, best_src;
	logic wr, rd;

	assign wr = REG_REQ.wr;
	assign rd = REG_REQ.rd;
	assign busy = (state_q != ST_IDLE);

	// Fast request pin crosses in through two flops
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			fast_meta_q <= 1'b0;
			fast_sync_q <= 1'b0;
			fast_prev_q <= 1'b0;
		end
		else
		begin
			fast_meta_q <= FAST_REQ_PIN;
			fast_sync_q <= fast_meta_q;
			fast_prev_q <= fast_sync_q;
		end
	end
	assign fast_rise = fast_sync_q && !fast_prev_q;

	// Pending fast request survives a descriptor transfer; a new edge beats the clear
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			fast_pend_q <= 1'b0;
		else if (fast_rise)
			fast_pend_q <= 1'b1;
		else if (start_fast)
			fast_pend_q <= 1'b0;
	end

	// Eligible descriptor triggers: flag raised, routed, above the level
	always_comb
	begin
		trig = 8'h00;
		for (int i = 0; i < CHANS; i++)
			trig[i] = flag_q[i] && req_q[i] && ({1'b0, prio_of(prio_q, 3'(i))} > CPU_LEVEL);
		pick = 4'h0;
		for (int i = CHANS - 1; i >= 0; i--)
			if (trig[i])
				pick = {1'b1, 3'(i)};
	end

	// Fast always goes first when idle; nothing starts while the circuit is in use
	assign start_fast = !busy && ctrl_en_q && fast_pend_q;
	assign start_desc = !busy && ctrl_en_q && !fast_pend_q && pick[3];

	xfer_engine u_engine (
		.CLK(CLK),
		.RST(RST),
		.START(start_fast || start_desc),
		.LEN(start_fast ? FAST_XFER_CYCLES : DESC_XFER_CYCLES),
		.BUSY(eng_busy),
		.DONE(eng_done)
	);

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			state_q <= ST_IDLE;
			chan_q <= 3'h0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					if (start_fast)
						state_q <= ST_FAST;
					else if (start_desc)
					begin
						state_q <= ST_DESC;
						chan_q <= pick[2:0];
					end
				end
				ST_FAST, ST_DESC:
				begin
					if (eng_done)
						state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign chan_hot = 8'h01 << chan_q;
	assign zero_evt = (state_q == ST_DESC) && eng_done && (count_q[chan_q] <= 8'h01);

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			for (int i = 0; i < CHANS; i++)
				count_q[i] <= BYTE_RST;
		else if (wr && hit(REG_REQ.addr, COUNT_LO_OFS))
			for (int i = 0; i < 4; i++)
				count_q[i] <= REG_REQ.wdata[i*8 +: 8];
		else if (wr && hit(REG_REQ.addr, COUNT_HI_OFS))
			for (int i = 0; i < 4; i++)
				count_q[i+4] <= REG_REQ.wdata[i*8 +: 8];
		else if ((state_q == ST_DESC) && eng_done && (count_q[chan_q] != 8'h00))
			count_q[chan_q] <= count_q[chan_q] - 8'h01;
	end

	// Factor flags: hardware sets win over any clear in the same cycle
	always_comb
	begin
		flag_set = FACTOR_EVT;
		if (zero_evt && done_irq_en_q[chan_q])
			flag_set = flag_set | chan_hot;
		flag_clr = 8'h00;
		if (wr && hit(REG_REQ.addr, FLAG_OFS))
			flag_clr = method_q ? REG_REQ.wdata[7:0] : ~REG_REQ.wdata[7:0];
		// Reset-only method consumes the trigger; read/write may retrigger
		if (start_desc && method_q)
			flag_clr = flag_clr | (8'h01 << pick[2:0]);
		if (zero_evt && !done_irq_en_q[chan_q])
			flag_clr = flag_clr | chan_hot;
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			flag_q <= BYTE_RST;
		else
			flag_q <= (flag_q & ~flag_clr) | flag_set;
	end

	// A CPU byte write lands on top of a completion clear in the same cycle
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			req_q <= BYTE_RST;
		else if (wr && hit(REG_REQ.addr, REQ_OFS))
			req_q <= REG_REQ.wdata[7:0];
		else if (zero_evt)
			req_q <= req_q & ~chan_hot;
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			irq_en_q <= BYTE_RST;
			done_irq_en_q <= BYTE_RST;
			method_q <= METHOD_RST;
			prio_q <= PRIO_RST;
			ctrl_en_q <= 1'b0;
		end
		else if (wr)
		begin
			if (hit(REG_REQ.addr, IRQ_EN_OFS))
				irq_en_q <= REG_REQ.wdata[7:0];
			if (hit(REG_REQ.addr, DONE_IRQ_EN_OFS))
				done_irq_en_q <= REG_REQ.wdata[7:0];
			if (hit(REG_REQ.addr, METHOD_OFS))
				method_q <= REG_REQ.wdata[METHOD_BIT];
			if (hit(REG_REQ.addr, PRIO_OFS))
				prio_q <= REG_REQ.wdata & 32'h7777_7777;
			if (hit(REG_REQ.addr, CTRL_OFS))
				ctrl_en_q <= REG_REQ.wdata[CTRL_EN_BIT];
		end
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			fast_flag_q <= 1'b0;
		else if ((state_q == ST_FAST) && eng_done)
			fast_flag_q <= 1'b1;
		else if (wr && hit(REG_REQ.addr, STATUS_OFS) && REG_REQ.wdata[STATUS_FAST_FLAG_BIT])
			fast_flag_q <= 1'b0;
	end

	// Base: word write, or lower half then upper half; bytes and busy writes dropped
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			base_q <= BASE_RST;
			base_hold_q <= 16'h0000;
			base_hold_ok_q <= 1'b0;
		end
		else if (wr && !busy)
		begin
			if (hit(REG_REQ.addr, BASE_LO_OFS) && (REG_REQ.size == SZ_WORD))
			begin
				base_q <= REG_REQ.wdata;
				base_hold_ok_q <= 1'b0;
			end
			else if (hit(REG_REQ.addr, BASE_LO_OFS) && (REG_REQ.size == SZ_HALF))
			begin
				base_hold_q <= REG_REQ.wdata[15:0];
				base_hold_ok_q <= 1'b1;
			end
			else if (hit(REG_REQ.addr, BASE_HI_OFS) && (REG_REQ.size == SZ_HALF)
				&& base_hold_ok_q)
			begin
				base_q <= {REG_REQ.wdata[15:0], base_hold_q};
				base_hold_ok_q <= 1'b0;
			end
		end
	end

	// Highest priority unrouted, enabled flag; nothing leaves while a transfer runs
	always_comb
	begin
		found = 1'b0;
		best_prio = 3'h0;
		best_src = 3'h0;
		for (int i = 0; i < CHANS; i++)
			if (flag_q[i] && irq_en_q[i] && !req_q[i]
				&& (!found || (prio_of(prio_q, 3'(i)) > best_prio)))
			begin
				found = 1'b1;
				best_prio = prio_of(prio_q, 3'(i));
				best_src = 3'(i);
			end
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			irq_q <= 1'b0;
			irq_prio_q <= 3'h0;
			irq_src_q <= 3'h0;
			osc_q <= 1'b0;
		end
		else
		begin
			irq_q <= !busy && !start_fast && !start_desc && found
				&& ({1'b0, best_prio} > CPU_LEVEL);
			irq_prio_q <= best_prio;
			irq_src_q <= best_src;
			osc_q <= SLEEP_MODE && ((FACTOR_EVT & req_q) != 8'h00);
		end
	end

	// Reads: base shows garbage-free zero while a transfer owns it
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			rdata_q <= 32'h0000_0000;
		else if (rd)
		begin
			rdata_q <= 32'h0000_0000;
			if (hit(REG_REQ.addr, BASE_LO_OFS) && !busy && (REG_REQ.size == SZ_WORD))
				rdata_q <= base_q;
			else if (hit(REG_REQ.addr, BASE_LO_OFS) && !busy && (REG_REQ.size == SZ_HALF))
				rdata_q <= {16'h0000, base_q[15:0]};
			else if (hit(REG_REQ.addr, BASE_HI_OFS) && !busy && (REG_REQ.size == SZ_HALF))
				rdata_q <= {16'h0000, base_q[31:16]};
			else if (hit(REG_REQ.addr, IRQ_EN_OFS))
				rdata_q <= {24'h000000, irq_en_q};
			else if (hit(REG_REQ.addr, FLAG_OFS))
				rdata_q <= {24'h000000, flag_q};
			else if (hit(REG_REQ.addr, REQ_OFS))
				rdata_q <= {24'h000000, req_q};
			else if (hit(REG_REQ.addr, DONE_IRQ_EN_OFS))
				rdata_q <= {24'h000000, done_irq_en_q};
			else if (hit(REG_REQ.addr, METHOD_OFS))
				rdata_q <= {31'h0000_0000, method_q};
			else if (hit(REG_REQ.addr, PRIO_OFS))
				rdata_q <= prio_q;
			else if (hit(REG_REQ.addr, CTRL_OFS))
				rdata_q <= {31'h0000_0000, ctrl_en_q};
			else if (hit(REG_REQ.addr, STATUS_OFS))
				rdata_q <= {24'h000000, fast_pend_q, chan_q, busy, eng_busy,
					state_q == ST_DESC, fast_flag_q};
			else if (hit(REG_REQ.addr, COUNT_LO_OFS))
				rdata_q <= {count_q[3], count_q[2], count_q[1], count_q[0]};
			else if (hit(REG_REQ.addr, COUNT_HI_OFS))
				rdata_q <= {count_q[7], count_q[6], count_q[5], count_q[4]};
		end
	end

	assign REG_RDATA = rdata_q;
	assign IRQ_REQ = irq_q;
	assign IRQ_PRIO = irq_prio_q;
	assign IRQ_SRC = irq_src_q;
	assign HS_OSC_RESTART = osc_q;
	assign BUS_GRANT = '{fast: state_q == ST_FAST, desc: state_q == ST_DESC,
		chan: chan_q, cpu: !busy};

	a_fast_first: assert property (@(posedge CLK) disable iff (RST)
		(!busy && ctrl_en_q && fast_pend_q) |=> (state_q == ST_FAST))
		else $error("fast request not granted first");
	a_fast_waits: assert property (@(posedge CLK) disable iff (RST)
		(state_q == ST_DESC) && fast_rise |=> (state_q != ST_FAST) && fast_pend_q)
		else $error("fast request cut into descriptor transfer");
	a_desc_after_fast: assert property (@(posedge CLK) disable iff (RST)
		(state_q == ST_FAST) |-> !start_desc ##1 (state_q != ST_DESC))
		else $error("descriptor start during fast transfer");
	a_irq_held: assert property (@(posedge CLK) disable iff (RST)
		(state_q == ST_DESC) [*2] |-> !IRQ_REQ)
		else $error("interrupt raised during descriptor transfer");
	a_level_gate: assert property (@(posedge CLK) disable iff (RST)
		start_desc |-> ({1'b0, prio_of(prio_q, pick[2:0])} > CPU_LEVEL))
		else $error("trigger accepted at or below level");
	a_zero_done: assert property (@(posedge CLK) disable iff (RST)
		zero_evt && done_irq_en_q[chan_q] && !(wr && hit(REG_REQ.addr, REQ_OFS))
		|=> !req_q[$past(chan_q)] && flag_q[$past(chan_q)])
		else $error("completion did not clear request and keep flag");
	a_no_irq_off: assert property (@(posedge CLK) disable iff (RST)
		zero_evt && !done_irq_en_q[chan_q] && !FACTOR_EVT[chan_q]
		|=> !flag_q[$past(chan_q)])
		else $error("disabled completion left a flag");
	// A completion with its interrupt off also clears a bit, so it is kept out here
	a_clear_one: assert property (@(posedge CLK) disable iff (RST)
		method_q && wr && hit(REG_REQ.addr, FLAG_OFS) && (flag_set == 8'h00)
		&& !start_desc && !zero_evt
		|=> flag_q == ($past(flag_q) & ~$past(REG_REQ.wdata[7:0])))
		else $error("reset-only clear wrong");
	a_clear_zero: assert property (@(posedge CLK) disable iff (RST)
		!method_q && wr && hit(REG_REQ.addr, FLAG_OFS) && (flag_set == 8'h00) && !zero_evt
		|=> flag_q == ($past(flag_q) & $past(REG_REQ.wdata[7:0])))
		else $error("read/write clear wrong");
	a_base_lock: assert property (@(posedge CLK) disable iff (RST)
		busy |=> $stable(base_q))
		else $error("base changed during transfer");

endmodule : dma_req_arbiter
`default_nettype wire

// >>> dma_req_arbiter_bench.sv
// Purpose: Self-checking bench for the DMA request arbiter
// Assumes: Reads answer one cycle after the strobe; nothing waits on the register port
// Notes: Grant lengths, bus sharing and interrupt masking are watched by a background monitor
`timescale 1ns/1ps
`default_nettype none
module dma_req_arbiter_bench
	import dma_arb_pkg::*;
;
	logic clk;
	logic rst;
	reg_req_s req;
	logic [31:0] rdata;
	logic fast_pin;
	logic [7:0] evt;
	logic [3:0] level;
	logic sleep;
	logic irq;
	logic [2:0] irq_prio;
	logic [2:0] irq_src;
	grant_s grant;
	logic osc;
	logic osc_seen;
	logic [31:0] d;
	int n_errors;
	int checked;
	int frun;
	int drun;

	dma_req_arbiter dma_req_arbiter_i (.CLK(clk), .RST(rst), .REG_REQ(req), .REG_RDATA(rdata),
		.FAST_REQ_PIN(fast_pin), .FACTOR_EVT(evt), .CPU_LEVEL(level), .SLEEP_MODE(sleep),
		.IRQ_REQ(irq), .IRQ_PRIO(irq_prio), .IRQ_SRC(irq_src), .BUS_GRANT(grant),
		.HS_OSC_RESTART(osc));
	cpu_side_model cpu_side_model_i (.clk(clk), .fast_req_pin(fast_pin), .factor_evt(evt),
		.cpu_level(level), .sleep_mode(sleep));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic wr(input logic [19:0] a, input logic [31:0] v, input acc_size_e s);
		@(posedge clk);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0, size: s};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [19:0] a, input acc_size_e s);
		@(posedge clk);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1, size: s};
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd

	task automatic rdchk(input logic [19:0] a, input acc_size_e s, input logic [31:0] e,
		input string what);
		rd(a, s);
		check(d, e, what);
	endtask : rdchk

	task automatic wait_desc();
		for (int i = 0; i < 30 && grant.desc !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
	endtask : wait_desc

	// Waits for a dozen quiet cycles so a pending fast request cannot slip in afterwards
	task automatic settle();
		int q = 0;
		for (int i = 0; i < 200 && q < 12; i++)
		begin
			@(posedge clk);
			#1;
			q = (grant.fast || grant.desc) ? 0 : q + 1;
		end
	endtask : settle

	always @(posedge clk)
	begin
		if (grant.fast === 1'b1)
			frun <= frun + 1;
		if (grant.desc === 1'b1)
			drun <= drun + 1;
		if (osc === 1'b1)
			osc_seen <= 1'b1;
		if (grant.fast || grant.desc)
			check({31'h0, irq}, 32'h0, "interrupt during transfer");
		if (grant.fast)
			check({30'h0, grant.cpu, grant.desc}, 32'h0, "fast grant shared");
	end

	task automatic reset_case();
		rdchk(METHOD_OFS, SZ_BYTE, 32'h1, "method after reset");
		rdchk(20'h40300, SZ_WORD, 32'h0, "unmapped read");
		wr(FLAG_OFS, 32'hFF, SZ_BYTE);
		wr(PRIO_OFS, 32'hFFFF_FFFF, SZ_WORD);
		rdchk(PRIO_OFS, SZ_WORD, 32'h7777_7777, "priority fields");
	endtask : reset_case

	task automatic base_case();
		wr(BASE_LO_OFS, 32'h0001_0000, SZ_WORD);
		wr(BASE_LO_OFS, 32'h0000_00FF, SZ_BYTE);
		wr(BASE_HI_OFS, 32'h0000_0055, SZ_HALF);
		rdchk(BASE_LO_OFS, SZ_WORD, 32'h0001_0000, "base after refused writes");
		wr(BASE_LO_OFS, 32'h0000_ABCC, SZ_HALF);
		wr(BASE_HI_OFS, 32'h0000_0012, SZ_HALF);
		rdchk(BASE_HI_OFS, SZ_HALF, 32'h0000_0012, "base upper half");
		rdchk(BASE_LO_OFS, SZ_HALF, 32'h0000_ABCC, "base lower half");
	endtask : base_case

	task automatic desc_case(input int ch, input logic irq_on, input logic slp);
		logic [7:0] m;
		m = 8'(32'h1 << ch);
		cpu_side_model_i.set_mode(4'h0, slp);
		// Setup is done with the engine disabled, then it is switched on
		wr(CTRL_OFS, 32'h0, SZ_WORD);
		wr(PRIO_OFS, 32'h3 << (4 * ch), SZ_WORD);
		wr(COUNT_LO_OFS, 32'h1 << (8 * ch), SZ_WORD);
		wr(DONE_IRQ_EN_OFS, {24'h0, irq_on ? m : 8'h00}, SZ_BYTE);
		wr(IRQ_EN_OFS, {24'h0, m}, SZ_BYTE);
		wr(REQ_OFS, {24'h0, m}, SZ_BYTE);
		wr(CTRL_OFS, 32'h1, SZ_WORD);
		frun = 0;
		drun = 0;
		osc_seen = 1'b0;
		fork
			cpu_side_model_i.fire_fast();
		join_none
		cpu_side_model_i.pulse_factor(m);
		wr(BASE_LO_OFS, 32'h0000_0040, SZ_WORD);
		settle();
		check(drun, 4, "descriptor grant length");
		check(frun, 8, "fast grant length");
		check({31'h0, osc_seen}, {31'h0, slp}, "oscillator restart");
		rdchk(REQ_OFS, SZ_BYTE, 32'h0, "request after count zero");
		rdchk(FLAG_OFS, SZ_BYTE, {24'h0, irq_on ? m : 8'h00}, "factor flag kept");
		rdchk(BASE_LO_OFS, SZ_WORD, 32'h0012_ABCC, "base during transfer");
		rd(STATUS_OFS, SZ_WORD);
		check({31'h0, d[0]}, 32'h1, "fast completion flag");
		wr(STATUS_OFS, 32'h1, SZ_WORD);
		rd(STATUS_OFS, SZ_WORD);
		check({31'h0, irq}, {31'h0, irq_on}, "completion interrupt");
		if (irq_on)
		begin
			check({29'h0, irq_src}, 32'(ch), "interrupt source");
			check({29'h0, irq_prio}, 32'h3, "interrupt priority");
		end
		wr(FLAG_OFS, {24'h0, m}, SZ_BYTE);
	endtask : desc_case

	task automatic level_case();
		cpu_side_model_i.set_mode(4'h5, 1'b0);
		wr(PRIO_OFS, 32'h0000_0300, SZ_WORD);
		wr(REQ_OFS, 32'h04, SZ_BYTE);
		drun = 0;
		cpu_side_model_i.pulse_factor(8'h04);
		repeat (20) @(posedge clk);
		check(drun, 0, "trigger below level");
		cpu_side_model_i.set_mode(4'h2, 1'b0);
		wait_desc();
		check({29'h0, grant.chan}, 32'h2, "descriptor channel");
		settle();
		check(drun, 4, "trigger above level");
	endtask : level_case

	task automatic flag_case();
		wr(REQ_OFS, 32'h0, SZ_BYTE);
		// No master enable sits in front of this block, so the source bit goes directly
		wr(IRQ_EN_OFS, 32'h0, SZ_BYTE);
		cpu_side_model_i.pulse_factor(8'h06);
		wr(FLAG_OFS, 32'h02, SZ_BYTE);
		rdchk(FLAG_OFS, SZ_BYTE, 32'h04, "write one clears only");
		wr(METHOD_OFS, 32'h0, SZ_BYTE);
		wr(FLAG_OFS, 32'h0, SZ_BYTE);
		rdchk(FLAG_OFS, SZ_BYTE, 32'h0, "write zero clears");
		rdchk(METHOD_OFS, SZ_BYTE, 32'h0, "method written");
	endtask : flag_case

	task automatic report_and_stop();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	// Whole run is a few hundred cycles; this span leaves a wide margin
	initial
	begin
		#100us;
		n_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		report_and_stop();
	end

	initial
	begin
		n_errors = 0;
		checked = 0;
		frun = 0;
		drun = 0;
		osc_seen = 1'b0;
		d = 32'h0;
		req = '0;
		rst = 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		reset_case();
		base_case();
		desc_case(0, 1'b1, 1'b0);
		desc_case(1, 1'b0, 1'b1);
		level_case();
		flag_case();
		report_and_stop();
	end
endmodule : dma_req_arbiter_bench
`default_nettype wire

// >>> xfer_engine.sv
// Purpose: Shared transfer circuit used by fast and descriptor transfers
// Assumes: Start is only raised while idle
// Notes: Done is a one-cycle pulse on the last busy cycle
`timescale 1ns/1ps
`default_nettype none
module xfer_engine
	import dma_arb_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic START,
	input wire logic [7:0] LEN,
	output logic BUSY,
	output logic DONE
);

	logic [7:0] left_q;
	logic busy_q;

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			left_q <= BYTE_RST;
			busy_q <= 1'b0;
		end
		else if (START && !busy_q)
		begin
			// A zero length still takes one cycle
			left_q <= (LEN == 8'h00) ? 8'h01 : LEN;
			busy_q <= 1'b1;
		end
		else if (busy_q)
		begin
			left_q <= left_q - 8'h01;
			if (left_q == 8'h01)
				busy_q <= 1'b0;
		end
	end

	assign BUSY = busy_q;
	assign DONE = busy_q && (left_q == 8'h01);

endmodule : xfer_engine
`default_nettype wire
